// ===== core/lcp_pkg.sv
package lcp_pkg;

  // clocking
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned US_PER_S   = 1_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;

  // channel geometry
  localparam int unsigned NUM_CH      = 24;
  localparam int unsigned CH_PER_GRP  = 3;
  localparam int unsigned CODE_W      = 6;
  localparam int unsigned HI_W        = 8;
  localparam int unsigned LO_W        = 4;
  localparam int unsigned PWM_W       = 12;
  localparam int unsigned ACC_W       = 24;
  localparam int unsigned BLK_W       = 18;
  localparam int unsigned FACTOR_W    = 10;
  localparam logic [PWM_W-1:0] PHASE_STEP = 12'h200;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_ENABLE    = 8'h04;
  localparam logic [7:0] ADDR_OUT_STAT  = 8'h08;
  localparam logic [7:0] ADDR_DIAG_STAT = 8'h0C;
  localparam logic [7:0] ADDR_FAILSAFE  = 8'h10;
  localparam logic [7:0] ADDR_CH_BASE   = 8'h40;

  // control word fields
  localparam int unsigned CTRL_RANGE_LSB = 0;
  localparam int unsigned CTRL_FREQ_LSB  = 2;
  localparam int unsigned CTRL_PS_BIT    = 6;
  localparam int unsigned CTRL_EXP_BIT   = 7;
  localparam int unsigned CTRL_SHARE_BIT = 8;
  localparam int unsigned CTRL_RES_BIT   = 9;
  localparam int unsigned CTRL_BLANK_LSB = 12;
  localparam logic [15:0] CTRL_MASK      = 16'hF3FF;
  localparam logic [1:0]  RANGE_RST      = 2'h3;
  localparam logic        RES_RST        = 1'b1;
  localparam logic [3:0]  BLANK_RST      = 4'h0;

  // channel word fields
  localparam int unsigned CH_CODE_LSB = 0;
  localparam int unsigned CH_HI_LSB   = 8;
  localparam int unsigned CH_LO_LSB   = 16;
  localparam int unsigned FS_BIT      = 0;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // blanking time in microseconds per code
  function automatic int unsigned blank_us(input logic [3:0] code);
    int unsigned t [16] = '{100, 20, 30, 50, 80, 150, 200, 300,
                            500, 800, 1000, 1200, 1500, 2000, 3000, 4000};
    return t[code];
  endfunction : blank_us

  function automatic logic [BLK_W-1:0] blank_cycles(input logic [3:0] code);
    return BLK_W'(blank_us(code) * CYC_PER_US);
  endfunction : blank_cycles

  // dimming frequency in hertz per code, monotonic
  function automatic int unsigned freq_hz(input logic [3:0] code);
    int unsigned f [16] = '{200, 250, 300, 400, 500, 600, 800, 1000,
                            1200, 1600, 2000, 4000, 6000, 10000, 15000, 20800};
    return f[code];
  endfunction : freq_hz

  // accumulator step so that the top PWM_W bits sweep 4096 counts per period
  function automatic logic [ACC_W-1:0] freq_step(input logic [3:0] code);
    longint unsigned s;
    s = (longint'(freq_hz(code)) << ACC_W) / longint'(CLK_HZ);
    return s[ACC_W-1:0];
  endfunction : freq_step

endpackage : lcp_pkg

// ===== core/lcp_dimming.sv
`timescale 1ns/1ps
// Behaviour
// - range code scales full current 64..512
// - disabled channel is fully off
// - enables clear to zero at reset
// - 6-bit current code per channel
// - 4096-step period, duty sets on time
// - 4-bit shared dimming frequency select
// - one microsecond pulses achievable
// - diagnostics wait for blanking expiry
// - blanking code table 20us..4000us
// - no phase shift: all aligned
// - phase shift: eight groups A..H
// - groups start one eighth apart
// - linear: high byte over low nibble
// - FFh/Fh gives full on
// - duty applies on high byte write
// - shared duty uses channel A0
// - share off keeps outputs until written
// - 8-bit mode: high/256, FFh full
// - exponential table maps high byte
// - curve and frequency load stored defaults
// - duties zero at reset, stored at failsafe
module lcp_dimming #(
  parameter logic       NV_EXP_SEL  = 1'b0,
  parameter logic [3:0] NV_FREQ_SEL = 4'h0,
  parameter logic [7:0] NV_DUTY_HI  = 8'h00,
  parameter logic [3:0] NV_DUTY_LO  = 4'h0
) (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write
  input  wire logic [7:0]              awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // axi4-lite read
  input  wire logic [7:0]              araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // fail-safe entry strobe from the device state machine
  input  wire logic                    failsafe_entry,
  // channel side
  output logic [23:0]                  channel_output,
  output logic [143:0]                 channel_current_code,
  output logic [lcp_pkg::FACTOR_W-1:0] full_range_factor,
  output logic [23:0]                  diag_ready
);

  localparam int unsigned N = lcp_pkg::NUM_CH;

  // monotonic exponential curve: 3-bit octave, 5-bit mantissa
  function automatic logic [12:0] exp_map(input logic [7:0] x);
    logic [13:0] v;
    v = 14'(({1'b1, x[4:0]}) << x[7:5]);
    return 13'((v >> 1) - 14'h0010);
  endfunction : exp_map

  // returns {full_on, duty}
  function automatic logic [12:0] map_duty(input logic [7:0] hi, input logic [3:0] lo,
                                           input logic expo, input logic res12);
    logic [12:0] r;
    r = 13'h0000;
    if (expo) begin
      r = exp_map(hi);
    end else if (res12) begin
      r = {({hi, lo} == 12'hFFF), hi, lo};
    end else begin
      r = {(hi == 8'hFF), hi, 4'h0};
    end
    return r;
  endfunction : map_duty

  // register state
  logic [15:0]             ctrl_ff, nxt_ctrl;
  logic [N-1:0]            en_ff, nxt_en;
  logic [N-1:0][5:0]       code_ff, nxt_code;
  logic [N-1:0][7:0]       hi_ff, nxt_hi;
  logic [N-1:0][3:0]       lo_ff, nxt_lo;
  logic [N-1:0][12:0]      app_ff, nxt_app;
  // bus state
  logic                    aw_got_ff, nxt_aw_got;
  logic                    w_got_ff, nxt_w_got;
  logic [7:0]              aw_addr_ff, nxt_aw_addr;
  logic [31:0]             w_data_ff, nxt_w_data;
  logic [3:0]              w_strb_ff, nxt_w_strb;
  logic                    awready_ff, nxt_awready;
  logic                    wready_ff, nxt_wready;
  logic                    bvalid_ff, nxt_bvalid;
  logic [1:0]              bresp_ff, nxt_bresp;
  logic                    arready_ff, nxt_arready;
  logic                    rvalid_ff, nxt_rvalid;
  logic [31:0]             rdata_ff, nxt_rdata;
  logic [1:0]              rresp_ff, nxt_rresp;
  // datapath state
  logic [lcp_pkg::ACC_W-1:0]    acc_ff, nxt_acc;
  logic [N-1:0]                 out_ff, nxt_out;
  logic [N-1:0][17:0]           blk_ff, nxt_blk;
  logic [N-1:0]                 rdy_ff, nxt_rdy;
  logic [lcp_pkg::FACTOR_W-1:0] factor_ff, nxt_factor;

  // decoded control fields
  logic [1:0] range_sel;
  logic [3:0] freq_sel, blank_sel;
  logic       ps_en, exp_sel, share_en, res12;
  assign range_sel = ctrl_ff[lcp_pkg::CTRL_RANGE_LSB +: 2];
  assign freq_sel  = ctrl_ff[lcp_pkg::CTRL_FREQ_LSB +: 4];
  assign blank_sel = ctrl_ff[lcp_pkg::CTRL_BLANK_LSB +: 4];
  assign ps_en     = ctrl_ff[lcp_pkg::CTRL_PS_BIT];
  assign exp_sel   = ctrl_ff[lcp_pkg::CTRL_EXP_BIT];
  assign share_en  = ctrl_ff[lcp_pkg::CTRL_SHARE_BIT];
  assign res12     = ctrl_ff[lcp_pkg::CTRL_RES_BIT];

  // write channel: address and data may arrive in either order
  logic        aw_take, w_take, wr_fire, fs_load, hi_write;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  wr_ch, rd_ch;
  assign aw_take = awvalid & awready_ff;
  assign w_take  = wvalid & wready_ff;
  assign wr_addr = aw_got_ff ? aw_addr_ff : awaddr;
  assign wr_data = w_got_ff ? w_data_ff : wdata;
  assign wr_strb = w_got_ff ? w_strb_ff : wstrb;
  assign wr_fire = (aw_got_ff | aw_take) & (w_got_ff | w_take);
  assign wr_ch   = 8'((wr_addr - lcp_pkg::ADDR_CH_BASE) >> 2);
  assign rd_ch   = 8'((araddr - lcp_pkg::ADDR_CH_BASE) >> 2);

  function automatic logic is_ch(input logic [7:0] a, input logic [7:0] idx);
    return (a >= lcp_pkg::ADDR_CH_BASE) && (a[1:0] == 2'h0) && (idx < 8'(N));
  endfunction : is_ch

  function automatic logic is_mapped(input logic [7:0] a, input logic [7:0] idx);
    return is_ch(a, idx) || a == lcp_pkg::ADDR_CTRL || a == lcp_pkg::ADDR_ENABLE ||
           a == lcp_pkg::ADDR_OUT_STAT || a == lcp_pkg::ADDR_DIAG_STAT ||
           a == lcp_pkg::ADDR_FAILSAFE;
  endfunction : is_mapped

  assign fs_load  = failsafe_entry | (wr_fire && wr_addr == lcp_pkg::ADDR_FAILSAFE &&
                    wr_strb[0] && wr_data[lcp_pkg::FS_BIT]);
  assign hi_write = wr_fire && is_ch(wr_addr, wr_ch) && wr_strb[1];

  always_comb begin
    nxt_aw_got  = aw_got_ff;
    nxt_w_got   = w_got_ff;
    nxt_aw_addr = aw_take ? awaddr : aw_addr_ff;
    nxt_w_data  = w_take ? wdata : w_data_ff;
    nxt_w_strb  = w_take ? wstrb : w_strb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
    if (wr_fire) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = is_mapped(wr_addr, wr_ch) ? lcp_pkg::RESP_OKAY : lcp_pkg::RESP_SLVERR;
    end else begin
      nxt_aw_got = aw_got_ff | aw_take;
      nxt_w_got  = w_got_ff | w_take;
    end
    nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
    nxt_wready  = ~nxt_w_got & ~nxt_bvalid;
  end

  // read channel: one cycle from address to data
  always_comb begin
    nxt_arready = arready_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (rvalid_ff && rready) begin
      nxt_rvalid  = 1'b0;
      nxt_arready = 1'b1;
    end
    if (arvalid && arready_ff) begin
      nxt_arready = 1'b0;
      nxt_rvalid  = 1'b1;
      nxt_rresp   = is_mapped(araddr, rd_ch) ? lcp_pkg::RESP_OKAY : lcp_pkg::RESP_SLVERR;
      nxt_rdata   = 32'h0000_0000;
      if (is_ch(araddr, rd_ch)) begin
        nxt_rdata[lcp_pkg::CH_CODE_LSB +: 6] = code_ff[rd_ch[4:0]];
        nxt_rdata[lcp_pkg::CH_HI_LSB +: 8]   = hi_ff[rd_ch[4:0]];
        nxt_rdata[lcp_pkg::CH_LO_LSB +: 4]   = lo_ff[rd_ch[4:0]];
      end else begin
        unique case (araddr)
          lcp_pkg::ADDR_CTRL:      nxt_rdata[15:0] = ctrl_ff;
          lcp_pkg::ADDR_ENABLE:    nxt_rdata[23:0] = en_ff;
          lcp_pkg::ADDR_OUT_STAT:  nxt_rdata[23:0] = out_ff;
          lcp_pkg::ADDR_DIAG_STAT: nxt_rdata[23:0] = rdy_ff;
          default:                 nxt_rdata = 32'h0000_0000;
        endcase
      end
    end
    // an idle read side keeps its address channel open
    if (!rvalid_ff && !nxt_rvalid) begin
      nxt_arready = 1'b1;
    end
  end

  // configuration and duty registers
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_en   = en_ff;
    nxt_code = code_ff;
    nxt_hi   = hi_ff;
    nxt_lo   = lo_ff;
    nxt_app  = app_ff;
    if (wr_fire && wr_addr == lcp_pkg::ADDR_CTRL) begin
      for (int b = 0; b < 2; b++) begin
        if (wr_strb[b]) begin
          nxt_ctrl[b*8 +: 8] = wr_data[b*8 +: 8] & lcp_pkg::CTRL_MASK[b*8 +: 8];
        end
      end
    end
    if (wr_fire && wr_addr == lcp_pkg::ADDR_ENABLE) begin
      for (int b = 0; b < 3; b++) begin
        if (wr_strb[b]) begin
          nxt_en[b*8 +: 8] = wr_data[b*8 +: 8];
        end
      end
    end
    if (wr_fire && is_ch(wr_addr, wr_ch)) begin
      if (wr_strb[0]) begin
        nxt_code[wr_ch[4:0]] = wr_data[lcp_pkg::CH_CODE_LSB +: 6];
      end
      if (wr_strb[2]) begin
        nxt_lo[wr_ch[4:0]] = wr_data[lcp_pkg::CH_LO_LSB +: 4];
      end
      if (wr_strb[1]) begin
        nxt_hi[wr_ch[4:0]]  = wr_data[lcp_pkg::CH_HI_LSB +: 8];
        nxt_app[wr_ch[4:0]] = map_duty(nxt_hi[wr_ch[4:0]], nxt_lo[wr_ch[4:0]],
                                       exp_sel, res12);
      end
    end
    // leaving shared mode freezes what every channel was showing
    if (share_en && !nxt_ctrl[lcp_pkg::CTRL_SHARE_BIT]) begin
      for (int i = 0; i < N; i++) begin
        nxt_app[i] = app_ff[0];
      end
    end
    if (fs_load) begin
      nxt_ctrl[lcp_pkg::CTRL_EXP_BIT]       = NV_EXP_SEL;
      nxt_ctrl[lcp_pkg::CTRL_FREQ_LSB +: 4] = NV_FREQ_SEL;
      for (int i = 0; i < N; i++) begin
        nxt_hi[i]  = NV_DUTY_HI;
        nxt_lo[i]  = NV_DUTY_LO;
        nxt_app[i] = map_duty(NV_DUTY_HI, NV_DUTY_LO, NV_EXP_SEL, res12);
      end
    end
  end

  // pwm timebase, channel outputs and blanking
  always_comb begin
    logic [11:0] cnt, ph;
    logic [12:0] d;
    cnt = 12'h000;
    ph  = 12'h000;
    d   = 13'h0000;
    // fractional step keeps the period exact at rates above clk/4096
    nxt_acc    = 24'(acc_ff + lcp_pkg::freq_step(freq_sel));
    cnt        = acc_ff[lcp_pkg::ACC_W-1 -: lcp_pkg::PWM_W];
    nxt_factor = 10'(10'h040 << range_sel);
    for (int i = 0; i < N; i++) begin
      d  = share_en ? app_ff[0] : app_ff[i];
      ph = ps_en ? 12'(cnt - 12'(lcp_pkg::PHASE_STEP * 12'(i / lcp_pkg::CH_PER_GRP)))
                 : cnt;
      nxt_out[i] = en_ff[i] & (d[12] | (ph < d[11:0]));
      if (!out_ff[i]) begin
        nxt_blk[i] = 18'h00000;
      end else if (blk_ff[i] < lcp_pkg::blank_cycles(blank_sel)) begin
        nxt_blk[i] = 18'(blk_ff[i] + 18'h00001);
      end else begin
        nxt_blk[i] = blk_ff[i];
      end
      // a period shorter than blanking never opens this window below full duty
      nxt_rdy[i] = out_ff[i] & (blk_ff[i] >= lcp_pkg::blank_cycles(blank_sel));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= {lcp_pkg::BLANK_RST, 2'h0, lcp_pkg::RES_RST, 1'b0, NV_EXP_SEL, 1'b0,
                  NV_FREQ_SEL, lcp_pkg::RANGE_RST};
      en_ff      <= '0;
      code_ff    <= '0;
      hi_ff      <= '0;
      lo_ff      <= '0;
      app_ff     <= '0;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= 2'h0;
      acc_ff     <= 24'h000000;
      out_ff     <= '0;
      blk_ff     <= '0;
      rdy_ff     <= '0;
      factor_ff  <= 10'h200;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      en_ff      <= nxt_en;
      code_ff    <= nxt_code;
      hi_ff      <= nxt_hi;
      lo_ff      <= nxt_lo;
      app_ff     <= nxt_app;
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      acc_ff     <= nxt_acc;
      out_ff     <= nxt_out;
      blk_ff     <= nxt_blk;
      rdy_ff     <= nxt_rdy;
      factor_ff  <= nxt_factor;
    end
  end

  assign awready              = awready_ff;
  assign wready               = wready_ff;
  assign bvalid               = bvalid_ff;
  assign bresp                = bresp_ff;
  assign arready              = arready_ff;
  assign rvalid               = rvalid_ff;
  assign rdata                = rdata_ff;
  assign rresp                = rresp_ff;
  assign channel_output       = out_ff;
  assign channel_current_code = code_ff;
  assign full_range_factor    = factor_ff;
  assign diag_ready           = rdy_ff;

  // checks
  logic share_fell;
  assign share_fell = share_en & ~nxt_ctrl[lcp_pkg::CTRL_SHARE_BIT];

  property p_range_factor;
    @(posedge aclk) disable iff (!aresetn)
      ##1 (factor_ff == 10'(10'h040 << $past(range_sel)));
  endproperty
  a_range_factor: assert property (p_range_factor)
    else $error("current range factor does not follow range code");

  property p_disabled_off;
    @(posedge aclk) disable iff (!aresetn)
      (en_ff == 24'h000000) [*2] |-> (out_ff == 24'h000000);
  endproperty
  a_disabled_off: assert property (p_disabled_off)
    else $error("disabled channel drove output");

  property p_reset_enables;
    @(posedge aclk) $past(!aresetn) && aresetn |-> (en_ff == 24'h000000);
  endproperty
  a_reset_enables: assert property (p_reset_enables)
    else $error("enables not cleared by reset");

  property p_full_on;
    @(posedge aclk) disable iff (!aresetn)
      (en_ff[5] && app_ff[5][12] && !share_en) [*2] |-> out_ff[5];
  endproperty
  a_full_on: assert property (p_full_on)
    else $error("full duty channel went low");

  property p_duty_hold;
    @(posedge aclk) disable iff (!aresetn)
      !hi_write && !share_fell && !fs_load |=> $stable(app_ff[7]);
  endproperty
  a_duty_hold: assert property (p_duty_hold)
    else $error("applied duty changed without high byte write");

  property p_aligned;
    @(posedge aclk) disable iff (!aresetn)
      (!ps_en && en_ff[0] && en_ff[23] && app_ff[0] == app_ff[23]) [*2]
      |-> (out_ff[0] == out_ff[23]);
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("unshifted channels not aligned");

  property p_shared;
    @(posedge aclk) disable iff (!aresetn)
      (share_en && !ps_en && en_ff[0] && en_ff[2]) [*2] |-> (out_ff[2] == out_ff[0]);
  endproperty
  a_shared: assert property (p_shared)
    else $error("shared duty not followed");

  property p_blank_wait;
    @(posedge aclk) disable iff (!aresetn)
      $rose(out_ff[1]) |-> !rdy_ff[1] [*8];
  endproperty
  a_blank_wait: assert property (p_blank_wait)
    else $error("diagnostics opened before blanking");

  property p_reset_duty;
    @(posedge aclk) $past(!aresetn) && aresetn
      |-> (hi_ff == '0) && (app_ff == '0) && (exp_sel == NV_EXP_SEL);
  endproperty
  a_reset_duty: assert property (p_reset_duty)
    else $error("duty or curve select wrong after reset");

  c_phase_shift: cover property (@(posedge aclk) disable iff (!aresetn)
    ps_en && $rose(out_ff[3]));
  c_diag_open: cover property (@(posedge aclk) disable iff (!aresetn) $rose(rdy_ff[0]));
  c_share_off: cover property (@(posedge aclk) disable iff (!aresetn) share_fell);
  c_failsafe: cover property (@(posedge aclk) disable iff (!aresetn) fs_load);

endmodule : lcp_dimming

// ===== test/lcp_led_model.sv
`timescale 1ns/1ps
// led strings: on-time and last turn-on cycle of each channel
module lcp_led_model (
  // clock and window control
  input  wire logic        aclk,
  input  wire logic        clr,
  // current from the channels
  input  wire logic [23:0] channel_output,
  // observations
  output int               on_cnt [24],
  output int               rise_cyc [24]
);
  int          cyc = 0;
  logic [23:0] prev = 24'h0;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    prev <= channel_output;
    for (int i = 0; i < 24; i++) begin
      if (clr)
        on_cnt[i] <= 0;
      else if (channel_output[i])
        on_cnt[i] <= on_cnt[i] + 1;
      if (channel_output[i] && !prev[i])
        rise_cyc[i] <= cyc;
    end
  end
endmodule : lcp_led_model

// ===== test/tb_led_channel_current_and_pwm_dimming.sv
`timescale 1ns/1ps
module tb_led_channel_current_and_pwm_dimming;
  // one dimming period at code F, in clocks
  localparam int W = 2404;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, failsafe_entry, clr;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  logic [1:0]   last_bresp;
  logic [23:0]  chan_out, diag_ready;
  logic [143:0] cur_code;
  logic [lcp_pkg::FACTOR_W-1:0] factor;
  int on_cnt [24];
  int rise_cyc [24];
  int num_errors, cmp_count;

  lcp_dimming #(.NV_FREQ_SEL(4'hF), .NV_DUTY_HI(8'hFF), .NV_DUTY_LO(4'hF)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .failsafe_entry(failsafe_entry), .channel_output(chan_out),
    .channel_current_code(cur_code), .full_range_factor(factor), .diag_ready(diag_ready));
  lcp_led_model led_u (.aclk(aclk), .clr(clr), .channel_output(chan_out),
    .on_cnt(on_cnt), .rise_cyc(rise_cyc));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // pwm counts drift by a clock or two against the window
  task automatic chk_near(input string what, input int exp, input int got);
    cmp_count++;
    if (got < exp - 3 || got > exp + 3) begin
      num_errors++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_near

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        last_bresp = bresp;
        bready <= 1'b0;
        return;
      end
    end
    num_errors++;
    close_out();
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                        input string what);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        chk(what, exp, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        return;
      end
    end
    num_errors++;
    close_out();
  endtask : rd_chk

  task automatic ch_wr(input int ch, input logic [7:0] hi, input logic [3:0] lo,
                       input logic [5:0] code, input logic [3:0] s);
    wr(8'(8'h40 + 4 * ch), {12'h0, lo, hi, 2'h0, code}, s);
  endtask : ch_wr

  // one full period, so the window phase does not matter
  task automatic meas(input int ch, input int exp, input string what);
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    tick(W);
    chk_near(what, exp, on_cnt[ch]);
  endtask : meas

  task automatic ph(input int ch, input int exp);
    chk_near("phase", exp, ((rise_cyc[ch] - rise_cyc[0]) % W + W) % W);
  endtask : ph

  function automatic int on_of(input int d);
    return d * W / 4096;
  endfunction : on_of

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, failsafe_entry, clr, aresetn} = 8'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    num_errors = 0;
    cmp_count = 0;
    tick(6);
    aresetn <= 1'b1;
    tick(2);
    chk("factor", 32'h200, {22'h0, factor});
    rd_chk(8'h00, 32'h0000023F, 2'h0, "ctrl");
    rd_chk(8'h04, 32'h0, 2'h0, "enable");
    rd_chk(8'h20, 32'h0, 2'h2, "unmapped");
    wr(8'h20, 32'h0, 4'hF);
    chk("bresp unmapped", 32'h2, {30'h0, last_bresp});
    rd_chk(8'h40, 32'h0, 2'h0, "duty reset");
    // blanking 20 us stays below the 48 us period
    for (int r = 0; r < 4; r++) begin
      wr(8'h00, 32'h0000123C | r, 4'hF);
      tick(2);
      chk("factor", 32'h40 << r, {22'h0, factor});
    end
    chk("bresp", 32'h0, {30'h0, last_bresp});
    ch_wr(23, 8'h00, 4'h0, 6'h3F, 4'hF);
    tick(2);
    chk("code", 32'h3F, {26'h0, cur_code[143:138]});
    ch_wr(0, 8'hFF, 4'hF, 6'h00, 4'hF);
    meas(0, 0, "disabled");
    wr(8'h04, 32'h00FFFFFF, 4'hF);
    tick(985);
    chk("diag early", 32'h0, {31'h0, diag_ready[0]});
    tick(25);
    chk("diag late", 32'h1, {31'h0, diag_ready[0]});
    rd_chk(8'h08, 32'h1, 2'h0, "out status");
    rd_chk(8'h0C, 32'h1, 2'h0, "diag status");
    meas(0, W, "full12");
    ch_wr(1, 8'h40, 4'h0, 6'h00, 4'hF);
    meas(1, on_of(1024), "lin12");
    ch_wr(1, 8'h00, 4'hF, 6'h00, 4'h4);
    meas(1, on_of(1024), "low only");
    ch_wr(1, 8'h40, 4'h0, 6'h00, 4'h2);
    meas(1, on_of(1039), "high applies");
    wr(8'h00, 32'h0000133F, 4'hF);
    meas(2, W, "shared");
    wr(8'h00, 32'h0000123F, 4'hF);
    meas(2, W, "share off");
    wr(8'h00, 32'h0000103F, 4'hF);
    ch_wr(3, 8'h80, 4'hF, 6'h00, 4'hF);
    meas(3, on_of(2048), "lin8");
    ch_wr(3, 8'hFF, 4'h0, 6'h00, 4'hF);
    meas(3, W, "full8");
    wr(8'h00, 32'h000012BF, 4'hF);
    ch_wr(3, 8'hFF, 4'hF, 6'h00, 4'hF);
    meas(3, on_of(4016), "expo");
    wr(8'h00, 32'h0000123F, 4'hF);
    ch_wr(0, 8'h80, 4'h0, 6'h00, 4'hF);
    ch_wr(3, 8'h80, 4'h0, 6'h00, 4'hF);
    ch_wr(21, 8'h80, 4'h0, 6'h00, 4'hF);
    tick(W);
    ph(3, 0);
    wr(8'h00, 32'h0000127F, 4'hF);
    tick(2 * W);
    ph(3, W / 8);
    ph(21, W * 7 / 8);
    wr(8'h00, 32'h000012C3, 4'hF);
    @(posedge aclk);
    failsafe_entry <= 1'b1;
    @(posedge aclk);
    failsafe_entry <= 1'b0;
    rd_chk(8'h00, 32'h0000127F, 2'h0, "ctrl reload");
    meas(5, W, "stored duty");
    close_out();
  end
endmodule : tb_led_channel_current_and_pwm_dimming
